// ===== verilog/bpp_pkg.sv
`default_nettype none
package bpp_pkg;
  localparam int PORT_WIDTH = 8;
  localparam int NUM_PORTS = 2;
  localparam int PORT_SEL_WIDTH = 1;
  localparam logic [7:0] MCU_CONTROL_RESET = 8'h00;
  localparam logic [7:0] MCU_CONTROL_WRITE_MASK = 8'h10;
  localparam int PULLUP_DISABLE_POS = 4;
  localparam logic [7:0] OUTPUT_VALUE_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] SAMPLE_RESET = 8'h00;
  localparam logic [1:0] LOC_OUTPUT_VALUE = 2'h0;
  localparam logic [1:0] LOC_DIRECTION = 2'h1;
  localparam logic [1:0] LOC_PIN_SAMPLE = 2'h2;
  localparam logic [1:0] LOC_MCU_CONTROL = 2'h3;
  typedef enum logic [1:0] {
    BPP_ACC_IDLE = 2'b00,
    BPP_ACC_READ = 2'b01,
    BPP_ACC_WRITE = 2'b10
  } bpp_access_type;

  function automatic logic [7:0] bpp_bit_update(input logic [7:0] old_value,
                                                input logic [7:0] mask,
                                                input logic [7:0] data);
    bpp_bit_update = (old_value & ~mask) | (data & mask);
  endfunction : bpp_bit_update
endpackage : bpp_pkg
`default_nettype wire

// ===== verilog/bpp_pin_sync.sv
`default_nettype none
module bpp_pin_sync
  import bpp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [PORT_WIDTH-1:0] pin_in,
  output logic [PORT_WIDTH-1:0] sample
);
  typedef struct packed {
    logic [PORT_WIDTH-1:0] sample;
  } bpp_sync_state_type;
  bpp_sync_state_type state;
  bpp_sync_state_type next_state;
  logic [PORT_WIDTH-1:0] latch_q;

  // Latch is open while the clock is high, so a pin edge lands in half to one and a half periods.
  always_latch begin
    if (clk) begin
      latch_q = pin_in;
    end
  end

  always_comb begin
    next_state = state;
    next_state.sample = latch_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '{sample: SAMPLE_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign sample = state.sample;
endmodule : bpp_pin_sync
`default_nettype wire

// ===== verilog/bpp_pad_ctrl.sv
`default_nettype none
module bpp_pad_ctrl
  import bpp_pkg::*;
(
  input wire logic [PORT_WIDTH-1:0] direction,
  input wire logic [PORT_WIDTH-1:0] output_value,
  input wire logic pullup_disable,
  input wire logic rst,
  output logic [PORT_WIDTH-1:0] pad_out,
  output logic [PORT_WIDTH-1:0] pad_oe_n,
  output logic [PORT_WIDTH-1:0] pullup_en
);
  // Reset acts combinationally so the pads float even before any clock edge.
  always_comb begin
    pad_out = output_value;
    pad_oe_n = rst ? {PORT_WIDTH{1'b1}} : ~direction;
    pullup_en = (rst || pullup_disable) ? '0 : (~direction & output_value);
  end
endmodule : bpp_pad_ctrl
`default_nettype wire

// ===== verilog/bpp_gpio.sv
`default_nettype none
// What this block does
// - A pin drives when its direction bit is one and listens when it is zero.
// - An input pin whose output-value bit is one has its pull-up switched on.
// - The pull-up is off whenever the output-value bit is zero or the pin is an output.
// - An output pin drives high for an output-value bit of one and low for zero.
// - Reset tri-states every pin at once, with or without a running clock.
// - The pin-sample location reads back the pins, not written data; writes to it act on output value.
// - Writing a one to a pin-sample bit inverts the matching output-value bit.
// - The global pull-up disable bit turns off every pull-up on every port.
// - Single bits of direction and output-value can change without touching others.
// - Each port has three separate locations: output value, direction and pin sample.
// - Pins not given to alternate functions keep working as plain general I/O.
// - Strobes are shared within a port; clock, clamp and pull-up disable span all ports.
// - The pin-sample bits can be read at any time, whatever the direction.
// - Each pin passes a clock-high latch then a rising-edge register before sampling.
module bpp_gpio
  import bpp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [PORT_SEL_WIDTH-1:0] PORT_SEL,
  input wire logic [1:0] LOC,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] WR_MASK,
  input wire logic [7:0] WR_DATA,
  output logic [7:0] RD_DATA,
  input wire logic SLEEP_CLAMP,
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0] ALT_ENABLE,
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0] ALT_OUT,
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0] ALT_OE,
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0] PAD_IN,
  output logic [NUM_PORTS*PORT_WIDTH-1:0] PAD_OUT,
  output logic [NUM_PORTS*PORT_WIDTH-1:0] PAD_OE_N,
  output logic [NUM_PORTS*PORT_WIDTH-1:0] PULLUP_EN,
  output logic [NUM_PORTS*PORT_WIDTH-1:0] PIN_IN_SYNC
);
  typedef struct packed {
    logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] output_value;
    logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] direction;
    logic [7:0] mcu_control;
    logic [7:0] rd_data;
  } bpp_state_type;
  bpp_state_type state;
  bpp_state_type next_state;
  bpp_access_type access;
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] sample;
  logic pullup_disable;

  always_comb begin
    if (WR_EN) begin
      access = BPP_ACC_WRITE;
    end else if (RD_EN) begin
      access = BPP_ACC_READ;
    end else begin
      access = BPP_ACC_IDLE;
    end
  end

  // The disable bit is one wire fanned out to every port.
  assign pullup_disable = state.mcu_control[PULLUP_DISABLE_POS];

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [PORT_WIDTH-1:0] pin_raw;
    logic [PORT_WIDTH-1:0] dir_eff;
    logic [PORT_WIDTH-1:0] val_eff;
    logic [PORT_WIDTH-1:0] alt;
    logic [PORT_WIDTH-1:0] gpio_out;
    logic [PORT_WIDTH-1:0] gpio_oe_n;
    logic [PORT_WIDTH-1:0] gpio_pu;
    assign alt = ALT_ENABLE[p*PORT_WIDTH +: PORT_WIDTH];
    // Override is per pin, so untouched pins stay plain general I/O.
    assign dir_eff = (alt & ALT_OE[p*PORT_WIDTH +: PORT_WIDTH])
                   | (~alt & state.direction[p]);
    assign val_eff = (alt & ALT_OUT[p*PORT_WIDTH +: PORT_WIDTH])
                   | (~alt & state.output_value[p]);
    // Clamp keeps a floating input from burning power while asleep.
    assign pin_raw = SLEEP_CLAMP ? '0 : PAD_IN[p*PORT_WIDTH +: PORT_WIDTH];

    bpp_pin_sync u_sync (
      .clk(CLK),
      .rst(RST),
      .pin_in(pin_raw),
      .sample(sample[p])
    );

    bpp_pad_ctrl u_pad (
      .direction(dir_eff),
      .output_value(val_eff),
      .pullup_disable(pullup_disable),
      .rst(RST),
      .pad_out(gpio_out),
      .pad_oe_n(gpio_oe_n),
      .pullup_en(gpio_pu)
    );

    assign PAD_OUT[p*PORT_WIDTH +: PORT_WIDTH] = gpio_out;
    assign PAD_OE_N[p*PORT_WIDTH +: PORT_WIDTH] = gpio_oe_n;
    assign PULLUP_EN[p*PORT_WIDTH +: PORT_WIDTH] = gpio_pu;
    assign PIN_IN_SYNC[p*PORT_WIDTH +: PORT_WIDTH] = sample[p];
  end

  always_comb begin
    next_state = state;
    case (access)
      BPP_ACC_WRITE: begin
        case (LOC)
          LOC_OUTPUT_VALUE: begin
            next_state.output_value[PORT_SEL] =
              bpp_bit_update(state.output_value[PORT_SEL], WR_MASK, WR_DATA);
          end
          LOC_DIRECTION: begin
            next_state.direction[PORT_SEL] =
              bpp_bit_update(state.direction[PORT_SEL], WR_MASK, WR_DATA);
          end
          LOC_PIN_SAMPLE: begin
            // Nothing is stored here; ones flip the output value instead.
            next_state.output_value[PORT_SEL] =
              state.output_value[PORT_SEL] ^ (WR_DATA & WR_MASK);
          end
          LOC_MCU_CONTROL: begin
            next_state.mcu_control = bpp_bit_update(state.mcu_control,
                                                    WR_MASK & MCU_CONTROL_WRITE_MASK,
                                                    WR_DATA);
          end
          default: begin
            next_state.mcu_control = state.mcu_control;
          end
        endcase
      end
      BPP_ACC_READ: begin
        case (LOC)
          LOC_OUTPUT_VALUE: next_state.rd_data = state.output_value[PORT_SEL];
          LOC_DIRECTION: next_state.rd_data = state.direction[PORT_SEL];
          LOC_PIN_SAMPLE: next_state.rd_data = sample[PORT_SEL];
          LOC_MCU_CONTROL: next_state.rd_data = state.mcu_control;
          default: next_state.rd_data = '0;
        endcase
      end
      default: begin
        next_state.rd_data = state.rd_data;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= '{output_value: {NUM_PORTS{OUTPUT_VALUE_RESET}},
                 direction: {NUM_PORTS{DIRECTION_RESET}},
                 mcu_control: MCU_CONTROL_RESET,
                 rd_data: 8'h00};
    end else begin
      state <= next_state;
    end
  end

  assign RD_DATA = state.rd_data;
endmodule : bpp_gpio
`default_nettype wire

// ===== bench/bpp_gpio_chk.sv
`default_nettype none
module bpp_gpio_chk
  import bpp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [PORT_SEL_WIDTH-1:0] PORT_SEL,
  input wire logic [1:0] LOC,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] WR_MASK,
  input wire logic [7:0] WR_DATA,
  input wire logic [7:0] RD_DATA,
  input wire logic SLEEP_CLAMP,
  input wire logic [15:0] PAD_IN,
  input wire logic [15:0] PAD_OUT,
  input wire logic [15:0] PAD_OE_N,
  input wire logic [15:0] PULLUP_EN,
  input wire logic [15:0] PIN_IN_SYNC
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire logic w0 = WR_EN && !PORT_SEL;
  a_reset_tristate: assert property (disable iff (1'b0) RST |-> PAD_OE_N == '1)
    else $error("pads driven in reset");
  a_pullup_gated: assert property ((PULLUP_EN & ~(PAD_OE_N & PAD_OUT)) == '0)
    else $error("pullup not gated");
  a_output_mask: assert property (w0 && LOC == LOC_OUTPUT_VALUE |=>
    PAD_OUT[7:0] == ($past(PAD_OUT[7:0] & ~WR_MASK) | $past(WR_DATA & WR_MASK)))
    else $error("output write wrong");
  a_direction_mask: assert property (w0 && LOC == LOC_DIRECTION |=>
    ~PAD_OE_N[7:0] == ($past(~PAD_OE_N[7:0] & ~WR_MASK) | $past(WR_DATA & WR_MASK)))
    else $error("direction write wrong");
  a_toggle_write: assert property (w0 && LOC == LOC_PIN_SAMPLE |=>
    PAD_OUT[7:0] == $past(PAD_OUT[7:0] ^ (WR_DATA & WR_MASK))) else $error("toggle wrong");
  a_pud_clears: assert property (WR_EN && LOC == LOC_MCU_CONTROL && WR_MASK[4] && WR_DATA[4]
    |=> PULLUP_EN == '0) else $error("pullup despite disable");
  a_sample_read: assert property (RD_EN && !WR_EN && !PORT_SEL && LOC == LOC_PIN_SAMPLE
    |=> RD_DATA == $past(PIN_IN_SYNC[7:0])) else $error("sample read wrong");
  a_sync_pins: assert property (!$past(RST) && !SLEEP_CLAMP && $stable(PAD_IN) ##1
    !SLEEP_CLAMP && $stable(PAD_IN) |-> PIN_IN_SYNC == PAD_IN) else $error("sync wrong");
endmodule : bpp_gpio_chk
bind bpp_gpio bpp_gpio_chk i_bpp_gpio_chk (.*);
`default_nettype wire

// ===== bench/bpp_pins_model.sv
`default_nettype none
module bpp_pins_model (
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe_n,
  input wire logic [15:0] pullup_en,
  input wire logic [15:0] ext_en,
  input wire logic [15:0] ext_val,
  output logic [15:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] noise = 16'h5a5a;
  // Undriven pins wander so that a missing pull-up cannot pass for a one.
  initial forever #100 noise = ~noise;
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
    | (pad_oe_n & ~ext_en & (pullup_en | noise));
endmodule : bpp_pins_model
`default_nettype wire

// ===== bench/bpp_gpio_tb_top.sv
`default_nettype none
module bpp_gpio_tb_top;
  import bpp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, sel = 0, wr = 0, rd = 0, clamp = 0;
  logic [1:0] loc = '0;
  logic [7:0] msk = '0, dat = '0, rdd;
  logic [15:0] po, oen, pu, pin, psync, ee = 16'h0, ev = 16'h0;
  logic [15:0] aen = 16'h0, aout = 16'h0, aoe = 16'h0;
  int error_cnt = 0, compares = 0;
  initial forever #50 clk = ~clk;
  bpp_gpio i_bpp_gpio (.CLK(clk), .RST(rst), .PORT_SEL(sel), .LOC(loc), .WR_EN(wr),
    .RD_EN(rd), .WR_MASK(msk), .WR_DATA(dat), .RD_DATA(rdd), .SLEEP_CLAMP(clamp),
    .ALT_ENABLE(aen), .ALT_OUT(aout), .ALT_OE(aoe), .PAD_IN(pin), .PAD_OUT(po),
    .PAD_OE_N(oen), .PULLUP_EN(pu), .PIN_IN_SYNC(psync));
  bpp_pins_model i_bpp_pins_model (.pad_out(po), .pad_oe_n(oen), .pullup_en(pu),
    .ext_en(ee), .ext_val(ev), .pad_in(pin));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic p, input logic [1:0] l,
                     input logic [7:0] m, input logic [7:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    sel = p;
    loc = l;
    msk = m;
    dat = d;
    @(negedge clk);
    wr = 0;
    rd = 0;
  endtask : acc
  task automatic rchk(input string n, input logic p, input logic [1:0] l, input logic [7:0] e);
    acc(0, p, l, 8'h00, 8'h00);
    chk(n, e, rdd);
  endtask : rchk
  task automatic t_drive();
    ee = 16'hc000;
    ev = 16'h4000;
    acc(1, 0, LOC_DIRECTION, 8'hff, 8'hff);
    acc(1, 0, LOC_OUTPUT_VALUE, 8'hff, 8'ha5);
    acc(1, 1, LOC_DIRECTION, 8'hff, 8'h0f);
    acc(1, 1, LOC_OUTPUT_VALUE, 8'hff, 8'h3c);
    chk("oe_n", 16'hf000, oen);
    chk("pad_out", 16'h3ca5, po);
    chk("pullup", 16'h3000, pu);
    rchk("sample p0", 0, LOC_PIN_SAMPLE, 8'ha5);
    rchk("sample p1", 1, LOC_PIN_SAMPLE, 8'h7c);
    chk("pin sync", 16'h7ca5, psync);
  endtask : t_drive
  task automatic t_toggle();
    acc(1, 0, LOC_PIN_SAMPLE, 8'h0f, 8'hff);
    rchk("toggled", 0, LOC_OUTPUT_VALUE, 8'haa);
    chk("port 1 out", 16'h003c, po[15:8]);
    rchk("sample kept", 0, LOC_PIN_SAMPLE, 8'haa);
  endtask : t_toggle
  task automatic t_bit();
    acc(1, 0, LOC_DIRECTION, 8'h01, 8'h00);
    acc(1, 0, LOC_OUTPUT_VALUE, 8'h01, 8'h01);
    chk("oe_n bit", 16'hf001, oen);
    chk("pad_out bit", 16'h3cab, po);
    chk("pullup bit", 16'h3001, pu);
  endtask : t_bit
  task automatic t_pud();
    acc(1, 0, LOC_MCU_CONTROL, 8'hff, 8'hff);
    chk("pud on", 16'h0000, pu);
    rchk("mcu control", 1, LOC_MCU_CONTROL, 8'h10);
    acc(1, 1, LOC_MCU_CONTROL, 8'h10, 8'h00);
    chk("pud off", 16'h3001, pu);
  endtask : t_pud
  task automatic t_alt();
    @(negedge clk);
    aen = 16'h0600;
    aoe = 16'h0200;
    aout = 16'h0200;
    @(negedge clk);
    chk("alt oe_n", 16'hf401, oen);
    chk("alt pad_out", 16'h3aab, po);
    chk("alt pullup", 16'h3001, pu);
    aen = 16'h0000;
    aoe = 16'h0000;
    aout = 16'h0000;
    @(negedge clk);
    chk("alt off oe_n", 16'hf001, oen);
  endtask : t_alt
  task automatic t_clamp();
    clamp = 1;
    repeat (2) @(negedge clk);
    rchk("clamped", 1, LOC_PIN_SAMPLE, 8'h00);
    clamp = 0;
  endtask : t_clamp
  task automatic finish_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial begin
    repeat (16) @(negedge clk);
    chk("oe_n reset", 16'hffff, oen);
    chk("pullup reset", 16'h0000, pu);
    rst = 0;
    t_drive();
    t_toggle();
    t_bit();
    t_pud();
    t_alt();
    t_clamp();
    // Reset lands between edges, so only the asynchronous path can float the pads.
    #10 rst = 1;
    #1 chk("async reset", 16'hffff, oen);
    finish_test();
  end
endmodule : bpp_gpio_tb_top
`default_nettype wire
